// ===== logic/mafc_match_unit.sv
// mafc_match_unit: compares one stored 48-bit address with the received destination
// assumes dest_i is stable in the cycle that en_i pulses
`timescale 1ns/10ps
module mafc_match_unit (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // compare request
   input  wire logic        en_i,
   input  wire logic [47:0] dest_i,
   input  wire logic [31:0] low_i,
   input  wire logic [15:0] high_i,
   // result
   output logic             hit_o
);

   typedef struct packed {
      logic hit;
   } mafc_mu_state_t;

   mafc_mu_state_t s;
   mafc_mu_state_t next_s;

   always_comb begin
      next_s = s;
      // result held until the next destination completes
      if (en_i) begin
         next_s.hit = (dest_i == {high_i, low_i});
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign hit_o = s.hit;

endmodule : mafc_match_unit

// ===== logic/mafc_pkg.sv
// mafc_pkg: register map, field positions, reset values and frame byte positions
// assumes a byte-addressed 32-bit classic wishbone bus and a byte-wide receive stream
package mafc_pkg;

   // ---------------------------------------------------------------
   // register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0]      ADR_MATCH_ADDR2_LOW     = 8'h00;
   localparam logic [7:0]      ADR_MATCH_ADDR2_HIGH    = 8'h04;
   localparam logic [7:0]      ADR_MATCH_ADDR3_LOW     = 8'h08;
   localparam logic [7:0]      ADR_MATCH_ADDR3_HIGH    = 8'h0c;
   localparam logic [7:0]      ADR_MATCH_ADDR4_LOW     = 8'h10;
   localparam logic [7:0]      ADR_MATCH_ADDR4_HIGH    = 8'h14;
   localparam logic [7:0]      ADR_TYPE_FIELD_MATCH    = 8'h18;
   localparam logic [7:0]      ADR_PHY_INTERFACE_SEL   = 8'h1c;
   localparam logic [2:0][7:0] ADR_LOW_TABLE  = {ADR_MATCH_ADDR4_LOW, ADR_MATCH_ADDR3_LOW,
                                                 ADR_MATCH_ADDR2_LOW};
   localparam logic [2:0][7:0] ADR_HIGH_TABLE = {ADR_MATCH_ADDR4_HIGH, ADR_MATCH_ADDR3_HIGH,
                                                 ADR_MATCH_ADDR2_HIGH};

   // ---------------------------------------------------------------
   // fields and reset values
   // ---------------------------------------------------------------
   localparam int              NUM_MATCH         = 3;
   localparam int              HIGH_WIDTH        = 16;
   localparam int              TYPE_WIDTH        = 16;
   localparam int              USRIO_RMII_BIT    = 0;
   localparam int              USRIO_TRANSCEIVER_CLOCK_GATE_BIT   = 1;
   localparam int              GROUP_BIT         = 0;
   localparam logic [31:0]     RST_LOW           = 32'h0000_0000;
   localparam logic [15:0]     RST_HIGH          = 16'h0000;
   localparam logic [15:0]     RST_TYPE          = 16'h0000;
   localparam logic            RST_RMII          = 1'b0;
   localparam logic            RST_TRANSCEIVER_CLOCK_GATE         = 1'b0;

   // ---------------------------------------------------------------
   // receive byte positions (0 = first destination byte)
   // ---------------------------------------------------------------
   localparam logic [3:0]      BYTE_DEST_LAST    = 4'h5;
   localparam logic [3:0]      BYTE_TYPE_HI      = 4'hc;
   localparam logic [3:0]      BYTE_TYPE_LO      = 4'hd;

   typedef enum logic [1:0] {RX_IDLE, RX_DEST, RX_SKIP} mafc_rx_st_t;

endpackage : mafc_pkg

// ===== logic/mafc_top.sv
// mafc_top: specific-address and type match registers, phy interface select, compare logic
// assumes a classic wishbone master and a byte stream from the receive path on clk_i
`timescale 1ns/10ps
module mafc_top (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // receive byte stream
   input  wire logic        rx_valid_i,
   input  wire logic        rx_sof_i,
   input  wire logic [7:0]  rx_byte_i,
   // match results
   output logic [2:0]       addr_hit_o,
   output logic             match_valid_o,
   output logic             dest_group_o,
   output logic [2:0]       entry_group_o,
   output logic             type_hit_o,
   output logic             type_valid_o,
   // phy side
   input  wire logic        xcvr_clk_i,
   output logic             xcvr_clk_o,
   output logic             rmii_mode_o
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [2:0][31:0]     low;
      logic [2:0][15:0]     high;
      logic [15:0]          type_val;
      logic                 rmii;
      logic                 clk_gate;
      logic                 ack;
      logic [31:0]          rdat;
      mafc_pkg::mafc_rx_st_t st;
      logic [3:0]           cnt;
      logic [47:0]          dest;
      logic [7:0]           type_msb;
      logic                 addr_done;
      logic                 hit_valid;
      logic                 group;
      logic                 type_done;
      logic                 type_hit;
   } mafc_state_t;

   mafc_state_t s;
   mafc_state_t next_s;
   logic        access;
   logic        wr;
   logic        rx_take;

   function automatic logic [31:0] mafc_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction : mafc_merge

   assign access  = wb_cyc_i && wb_stb_i && !s.ack;
   assign wr      = access && wb_we_i;
   // compare path frozen while the transceiver clock is gated off
   assign rx_take = s.clk_gate && rx_valid_i;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [31:0] tmp;
      tmp            = '0;
      next_s         = s;
      next_s.ack     = access;
      next_s.addr_done = 1'b0;
      next_s.hit_valid = s.addr_done;
      next_s.type_done = 1'b0;
      if (access) begin
         next_s.rdat = '0;
      end
      for (int i = 0; i < mafc_pkg::NUM_MATCH; i++) begin
         if (access && wb_adr_i == mafc_pkg::ADR_LOW_TABLE[i]) begin
            next_s.rdat = s.low[i];
            if (wr) begin
               next_s.low[i] = mafc_merge(s.low[i], wb_dat_i, wb_sel_i);
            end
         end
         if (access && wb_adr_i == mafc_pkg::ADR_HIGH_TABLE[i]) begin
            next_s.rdat = {16'h0000, s.high[i]};
            if (wr) begin
               tmp            = mafc_merge({16'h0000, s.high[i]}, wb_dat_i, wb_sel_i);
               next_s.high[i] = tmp[15:0];
            end
         end
      end
      if (access && wb_adr_i == mafc_pkg::ADR_TYPE_FIELD_MATCH) begin
         next_s.rdat = {16'h0000, s.type_val};
         if (wr) begin
            tmp             = mafc_merge({16'h0000, s.type_val}, wb_dat_i, wb_sel_i);
            next_s.type_val = tmp[15:0];
         end
      end
      if (access && wb_adr_i == mafc_pkg::ADR_PHY_INTERFACE_SEL) begin
         next_s.rdat = {30'h0, s.clk_gate, s.rmii};
         if (wr && wb_sel_i[0]) begin
            next_s.rmii     = wb_dat_i[mafc_pkg::USRIO_RMII_BIT];
            next_s.clk_gate = wb_dat_i[mafc_pkg::USRIO_TRANSCEIVER_CLOCK_GATE_BIT];
         end
      end
      // receive side: destination bytes in arrival order, then type field
      if (!s.clk_gate) begin
         next_s.st = mafc_pkg::RX_IDLE;
      end else if (rx_take && rx_sof_i) begin
         next_s.dest      = {40'h0, rx_byte_i};
         next_s.cnt       = 4'h1;
         next_s.st        = mafc_pkg::RX_DEST;
      end else if (rx_take) begin
         next_s.cnt = 4'(s.cnt + 4'h1);
         case (s.st)
            mafc_pkg::RX_DEST: begin
               next_s.dest[8*s.cnt +: 8] = rx_byte_i;
               if (s.cnt == mafc_pkg::BYTE_DEST_LAST) begin
                  next_s.addr_done = 1'b1;
                  next_s.group     = s.dest[mafc_pkg::GROUP_BIT];
                  next_s.st        = mafc_pkg::RX_SKIP;
               end
            end
            mafc_pkg::RX_SKIP: begin
               if (s.cnt == mafc_pkg::BYTE_TYPE_HI) begin
                  next_s.type_msb = rx_byte_i;
               end
               if (s.cnt == mafc_pkg::BYTE_TYPE_LO) begin
                  next_s.type_done = 1'b1;
                  next_s.type_hit  = ({s.type_msb, rx_byte_i} == s.type_val);
                  next_s.st        = mafc_pkg::RX_IDLE;
               end
            end
            default: begin
               next_s.cnt = s.cnt;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s          <= '0;
         s.low      <= {3{mafc_pkg::RST_LOW}};
         s.high     <= {3{mafc_pkg::RST_HIGH}};
         s.type_val <= mafc_pkg::RST_TYPE;
         s.rmii     <= mafc_pkg::RST_RMII;
         s.clk_gate <= mafc_pkg::RST_TRANSCEIVER_CLOCK_GATE;
         s.st       <= mafc_pkg::RX_IDLE;
      end else begin
         s <= next_s;
      end
   end

   // ---------------------------------------------------------------
   // per-entry comparators
   // ---------------------------------------------------------------
   for (genvar g = 0; g < mafc_pkg::NUM_MATCH; g++) begin : g_match
      mafc_match_unit u_match (
         .clk_i  (clk_i),
         .rst_i  (rst_i),
         .en_i   (s.addr_done),
         .dest_i (s.dest),
         .low_i  (s.low[g]),
         .high_i (s.high[g]),
         .hit_o  (addr_hit_o[g])
      );
      assign entry_group_o[g] = s.low[g][mafc_pkg::GROUP_BIT];
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign wb_dat_o      = s.rdat;
   assign wb_ack_o      = s.ack;
   assign match_valid_o = s.hit_valid;
   assign dest_group_o  = s.group;
   assign type_hit_o    = s.type_hit;
   assign type_valid_o  = s.type_done;
   assign rmii_mode_o   = s.rmii;
   // plain and gate: software should toggle the gate only while the phy clock is low
   assign xcvr_clk_o    = xcvr_clk_i & s.clk_gate;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   sequence seq_wr_low0;
      wr && wb_adr_i == mafc_pkg::ADR_MATCH_ADDR2_LOW && wb_sel_i == 4'hf;
   endsequence
   sequence seq_rd_high;
      access && !wb_we_i && (wb_adr_i == mafc_pkg::ADR_MATCH_ADDR3_HIGH);
   endsequence
   sequence seq_wr_usrio;
      wr && wb_adr_i == mafc_pkg::ADR_PHY_INTERFACE_SEL && wb_sel_i[0];
   endsequence
   sequence seq_type_last;
      rx_take && !rx_sof_i && s.st == mafc_pkg::RX_SKIP && s.cnt == mafc_pkg::BYTE_TYPE_LO;
   endsequence

   AST_LOW_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      seq_wr_low0 |=> s.low[0] == $past(wb_dat_i))
      else $error("low match word not stored");
   AST_GROUP_FLAG: assert property (@(posedge clk_i) disable iff (rst_i)
      s.addr_done |=> match_valid_o && dest_group_o == $past(s.dest[0]))
      else $error("group flag wrong");
   AST_FIRST_BYTE: assert property (@(posedge clk_i) disable iff (rst_i)
      (rx_take && rx_sof_i) |=> s.dest[7:0] == $past(rx_byte_i) && s.cnt == 4'h1)
      else $error("first destination byte misplaced");
   AST_TYPE_CMP: assert property (@(posedge clk_i) disable iff (rst_i)
      seq_type_last |=> type_valid_o
                        && type_hit_o == ({$past(s.type_msb), $past(rx_byte_i)}
                                          == $past(s.type_val)))
      else $error("type compare wrong");
   AST_RMII_SEL: assert property (@(posedge clk_i) disable iff (rst_i)
      seq_wr_usrio |=> rmii_mode_o == $past(wb_dat_i[0]) ##1 wb_ack_o == 1'b0)
      else $error("rmii select not applied");
   AST_CLK_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
      !s.clk_gate |-> !xcvr_clk_o && !(s.addr_done || s.type_done) [*1] ##1 !type_valid_o)
      else $error("transceiver clock passed while gated");
   AST_HIGH_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
      seq_rd_high |=> wb_ack_o && wb_dat_o[31:16] == 16'h0000
                      && wb_dat_o[15:0] == $past(s.high[1]))
      else $error("high word read wrong");

   // ---------------------------------------------------------------
   // further bus and receive checks
   // ---------------------------------------------------------------
   // registered ack: one pulse per request; a stb still held after ack is taken again two cycles after the first
   sequence seq_rd_low0;
      access && !wb_we_i && (wb_adr_i == mafc_pkg::ADR_MATCH_ADDR2_LOW);
   endsequence
   sequence seq_wr_high2;
      wr && wb_adr_i == mafc_pkg::ADR_MATCH_ADDR4_HIGH && wb_sel_i == 4'hf;
   endsequence
   sequence seq_wr_type;
      wr && wb_adr_i == mafc_pkg::ADR_TYPE_FIELD_MATCH && wb_sel_i == 4'hf;
   endsequence
   sequence seq_rd_type;
      access && !wb_we_i && (wb_adr_i == mafc_pkg::ADR_TYPE_FIELD_MATCH);
   endsequence
   sequence seq_rd_unmapped;
      access && !wb_we_i && (wb_adr_i > mafc_pkg::ADR_PHY_INTERFACE_SEL);
   endsequence
   sequence seq_dest_second;
      rx_take && !rx_sof_i && s.st == mafc_pkg::RX_DEST && s.cnt == 4'h1;
   endsequence
   sequence seq_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   AST_ACK_ONCE: assert property (@(posedge clk_i) disable iff (rst_i)
      access |=> seq_ack_pulse)
      else $error("ack not a single pulse");

   AST_LOW_READ: assert property (@(posedge clk_i) disable iff (rst_i)
      seq_rd_low0 |=> wb_ack_o && wb_dat_o == $past(s.low[0]))
      else $error("low match word read wrong");

   AST_UNMAPPED_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
      seq_rd_unmapped |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");

   AST_DEST_ORDER: assert property (@(posedge clk_i) disable iff (rst_i)
      seq_dest_second |=> s.dest[15:8] == $past(rx_byte_i)
                          && s.dest[7:0] == $past(s.dest[7:0]))
      else $error("second destination byte misplaced");

   // full 48-bit compare, no masking: a partly written entry stays active and can hit on its current value
   for (genvar h = 0; h < mafc_pkg::NUM_MATCH; h++) begin : g_hit_chk
      AST_ENTRY_HIT: assert property (@(posedge clk_i) disable iff (rst_i)
         s.addr_done |=> addr_hit_o[h]
                         == ($past(s.dest) == {$past(s.high[h]), $past(s.low[h])}))
         else $error("entry compare wrong");
   end

   AST_HIGH_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      seq_wr_high2 |=> s.high[2] == $past(wb_dat_i[15:0]))
      else $error("high match word not stored");

   AST_TYPE_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      seq_wr_type |=> s.type_val == $past(wb_dat_i[15:0]))
      else $error("type value not stored");

   AST_TYPE_READ: assert property (@(posedge clk_i) disable iff (rst_i)
      seq_rd_type |=> wb_ack_o && wb_dat_o == {16'h0000, $past(s.type_val)})
      else $error("type value read wrong");

   AST_CLK_GATE_SET: assert property (@(posedge clk_i) disable iff (rst_i)
      seq_wr_usrio |=> s.clk_gate == $past(wb_dat_i[mafc_pkg::USRIO_TRANSCEIVER_CLOCK_GATE_BIT]))
      else $error("clock gate bit not applied");

   AST_GATED_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
      !s.clk_gate |=> s.st == mafc_pkg::RX_IDLE)
      else $error("receive side ran while gated");

endmodule : mafc_top

// ===== tb/mafc_phy_model.sv
// mafc_phy_model: transceiver stand-in, makes the receive clock and byte stream
// assumes send_frame is called from one bench process at a time
`timescale 1ns/10ps
module mafc_phy_model (
   // clock
   input  wire logic       clk_i,
   // phy side outputs
   output logic            xcvr_clk_o,
   output logic            rx_valid_o,
   output logic            rx_sof_o,
   output logic [7:0]      rx_byte_o
);
   logic busy;

   // ---------------------------------------------------------------
   // free-running transceiver clock, unrelated to clk_i
   // ---------------------------------------------------------------
   initial begin
      {busy, rx_valid_o, rx_sof_o, rx_byte_o, xcvr_clk_o} = '0;
      forever #10.3 xcvr_clk_o = ~xcvr_clk_o;
   end

   // idle bytes keep changing so a stale byte is never mistaken for data
   always @(posedge clk_i) begin
      if (!busy) rx_byte_o <= rx_byte_o + 8'h35;
   end

   // ---------------------------------------------------------------
   // one frame header: dest bytes 0..5, source 6..11, type 12..13
   // ---------------------------------------------------------------
   task automatic send_frame(input logic [47:0] dest, input logic [15:0] typ);
      logic [111:0] bytes;
      bytes = {typ[7:0], typ[15:8], 48'ha5a5_5a5a_0f0f, dest};
      busy = 1'b1;
      for (int k = 0; k < 14; k++) begin
         @(posedge clk_i);
         {rx_valid_o, rx_sof_o, rx_byte_o} <= {1'b1, k == 0, bytes[8*k+:8]};
      end
      @(posedge clk_i);
      {rx_valid_o, rx_sof_o} <= 2'b00;
      busy = 1'b0;
   endtask : send_frame
endmodule : mafc_phy_model

// ===== tb/tb.sv
// tb: self-checking bench for mafc_top, random registers and frames
// assumes mafc_phy_model supplies the transceiver clock and receive stream
`timescale 1ns/10ps
module tb;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, xcvr_clk_i;
   logic        xcvr_clk_o, rmii_mode_o, rx_valid_i, rx_sof_i, match_valid_o;
   logic        dest_group_o, type_hit_o, type_valid_o, gate;
   logic [7:0]  wb_adr_i, rx_byte_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, r, lo [3];
   logic [15:0] hi [3], tv;
   logic [2:0]  addr_hit_o, entry_group_o;
   logic [47:0] d;
   int          err_count, compares, mv_n, tv_n;

   mafc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_valid_i(rx_valid_i),
      .rx_sof_i(rx_sof_i), .rx_byte_i(rx_byte_i), .addr_hit_o(addr_hit_o),
      .match_valid_o(match_valid_o), .dest_group_o(dest_group_o),
      .entry_group_o(entry_group_o), .type_hit_o(type_hit_o), .type_valid_o(type_valid_o),
      .xcvr_clk_i(xcvr_clk_i), .xcvr_clk_o(xcvr_clk_o), .rmii_mode_o(rmii_mode_o));

   mafc_phy_model i_phy (.clk_i(clk_i), .xcvr_clk_o(xcvr_clk_i), .rx_valid_o(rx_valid_i),
      .rx_sof_o(rx_sof_i), .rx_byte_o(rx_byte_i));

   // ---------------------------------------------------------------
   // checking helpers
   // ---------------------------------------------------------------
   task automatic report_and_stop;
      if (err_count == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [2:0] exp_hit(input logic [47:0] a);
      for (int i = 0; i < 3; i++) exp_hit[i] = (a === {hi[i], lo[i]});
   endfunction : exp_hit

   // classic single cycle; waits for ack with a bound, takes data at that edge
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, adr, 4'hf, dat};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) err_count++;
      r = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask : wb

   task automatic frame(input logic [47:0] a, input logic [15:0] t, input logic on);
      int mv;
      int tn;
      mv = mv_n;
      tn = tv_n;
      i_phy.send_frame(a, t);
      repeat (4) @(posedge clk_i);
      chk(48'(mv_n - mv), 48'(on));
      chk(48'(tv_n - tn), 48'(on));
      if (on) begin
         chk(48'(addr_hit_o), 48'(exp_hit(a)));
         chk(48'(dest_group_o), 48'(a[0]));
         chk(48'(type_hit_o), 48'(t === tv));
      end
   endtask : frame

   // ---------------------------------------------------------------
   // clock, monitors, watchdog
   // ---------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      if (match_valid_o === 1'b1) mv_n++;
      if (type_valid_o === 1'b1) tv_n++;
   end

   // gated clock is combinational; skipped while a register access is open
   always @(xcvr_clk_i) begin
      #0.1;
      if (!wb_cyc_i && !rst_i) chk(48'(xcvr_clk_o), 48'(xcvr_clk_i & gate));
   end

   initial begin
      #(25 * 20000);
      err_count++;
      report_and_stop;
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      rst_i = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, gate} = 4'h0;
      {wb_adr_i, wb_sel_i, wb_dat_i} = 44'h0;
      void'($urandom(34255));
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int a = 0; a < 36; a += 4) begin
         wb(1'b0, 8'(a), 32'h0);
         chk(48'(r), 48'h0);
      end
      for (int i = 0; i < 3; i++) begin
         lo[i] = $urandom | 32'(i == 0);
         hi[i] = 16'($urandom);
         wb(1'b1, mafc_pkg::ADR_LOW_TABLE[i], lo[i]);
         wb(1'b1, mafc_pkg::ADR_HIGH_TABLE[i], {16'hffff, hi[i]});
      end
      tv = 16'($urandom);
      wb(1'b1, mafc_pkg::ADR_TYPE_FIELD_MATCH, {16'hc3c3, tv});
      wb(1'b1, 8'h24, 32'hffff_ffff);
      wb(1'b0, 8'h24, 32'h0);
      chk(48'(r), 48'h0);
      for (int i = 0; i < 3; i++) begin
         wb(1'b0, mafc_pkg::ADR_LOW_TABLE[i], 32'h0);
         chk(48'(r), 48'(lo[i]));
         wb(1'b0, mafc_pkg::ADR_HIGH_TABLE[i], 32'h0);
         chk(48'(r), 48'({16'h0, hi[i]}));
      end
      wb(1'b0, mafc_pkg::ADR_TYPE_FIELD_MATCH, 32'h0);
      chk(48'(r), 48'(tv));
      chk(48'(entry_group_o), 48'({lo[2][0], lo[1][0], lo[0][0]}));
      for (int m = 0; m < 4; m++) begin
         wb(1'b1, mafc_pkg::ADR_PHY_INTERFACE_SEL, 32'(m));
         gate = m[1];
         wb(1'b0, mafc_pkg::ADR_PHY_INTERFACE_SEL, 32'h0);
         chk(48'(r), 48'(m));
         chk(48'(rmii_mode_o), 48'(m[0]));
         repeat (20) @(posedge clk_i);
      end
      for (int i = 0; i < 3; i++) frame({hi[i], lo[i]}, tv, 1'b1);
      d = {<<8{hi[0], lo[0]}};
      frame(d, tv ^ 16'h0100, 1'b1);
      frame({hi[1] ^ 16'h8000, lo[1]}, tv, 1'b1);
      frame({16'($urandom), 32'($urandom)}, 16'($urandom), 1'b1);
      wb(1'b1, mafc_pkg::ADR_PHY_INTERFACE_SEL, 32'h0);
      gate = 1'b0;
      frame({hi[2], lo[2]}, tv, 1'b0);
      report_and_stop;
   end
endmodule : tb
